/* File: hdl/pmem_pkg.sv */
// constants and types shared by the program store and its fetch control
package pmem_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int PC_W    = 24;
  localparam int INSTR_W = 24;
  localparam int WORD_W  = 16;
  localparam int UPPER_W = 8;
  localparam int OP_W    = 8;
  localparam int IDX_W   = 10;
  localparam int IDX_LSB = 1;
  localparam int IDX_MSB = IDX_W + IDX_LSB - 1;
  localparam int OP_LSB  = INSTR_W - OP_W;
  localparam int DEPTH   = 1 << IDX_W;

  // ****************************************************************
  // addresses
  // ****************************************************************
  localparam logic [PC_W-1:0]    PC_RESET = 24'h000000;
  localparam logic [PC_W-1:0]    VEC_BASE = 24'h000000;
  localparam logic [PC_W-1:0]    TGT_ADDR = 24'h000002;
  localparam logic [PC_W-1:0]    VEC_TOP  = 24'h000200;
  localparam logic [PC_W-1:0]    PC_STEP  = 24'h000002;
  localparam logic [UPPER_W-1:0] UPPER_PAD = 8'h00;

  // ****************************************************************
  // reset vector walk
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_VEC_OP   = 2'h0,
    ST_VEC_TGT  = 2'h1,
    ST_VEC_JUMP = 2'h3,
    ST_RUN      = 2'h2
  } fetch_state_t;

endpackage

/* File: hdl/pstore_if.sv */
// signals between the fetch control and the program store
`timescale 1ns/1ps
`default_nettype none
interface pstore_if;
  import pmem_pkg::*;
  logic [IDX_W-1:0]   fa_idx;
  logic [INSTR_W-1:0] fa_data;
  logic [IDX_W-1:0]   db_idx;
  logic               db_hi;
  logic [WORD_W-1:0]  db_data;
  logic               wr_en;
  logic               wr_hi;
  logic [IDX_W-1:0]   wr_idx;
  logic [WORD_W-1:0]  wr_data;

  modport ctrl (
    output fa_idx, db_idx, db_hi, wr_en, wr_hi, wr_idx, wr_data,
    input  fa_data, db_data
  );
  modport store (
    input  fa_idx, db_idx, db_hi, wr_en, wr_hi, wr_idx, wr_data,
    output fa_data, db_data
  );
endinterface
`default_nettype wire

/* File: hdl/program_store.sv */
// program store: lower and upper word arrays, registered reads
`timescale 1ns/1ps
`default_nettype none
module program_store
  import pmem_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // store side
  pstore_if.store   bus
);

  logic [WORD_W-1:0]  lower_mem [DEPTH];
  logic [UPPER_W-1:0] upper_mem [DEPTH];
  logic [INSTR_W-1:0] fa_data_r;
  logic [WORD_W-1:0]  db_data_r;
  logic [INSTR_W-1:0] fa_data_nxt;
  logic [WORD_W-1:0]  db_data_nxt;

  // ****************************************************************
  // arrays
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (bus.wr_en && bus.wr_hi) begin
      upper_mem[bus.wr_idx] <= bus.wr_data[UPPER_W-1:0];
    end
    if (bus.wr_en && !bus.wr_hi) begin
      lower_mem[bus.wr_idx] <= bus.wr_data;
    end
  end

  // ****************************************************************
  // read ports
  // ****************************************************************
  always_comb begin
    fa_data_nxt = {upper_mem[bus.fa_idx], lower_mem[bus.fa_idx]};
    if (bus.db_hi) begin
      db_data_nxt = {UPPER_PAD, upper_mem[bus.db_idx]};
    end else begin
      db_data_nxt = lower_mem[bus.db_idx];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fa_data_r <= '0;
      db_data_r <= '0;
    end else begin
      fa_data_r <= fa_data_nxt;
      db_data_r <= db_data_nxt;
    end
  end

  assign bus.fa_data = fa_data_r;
  assign bus.db_data = db_data_r;

endmodule
`default_nettype wire

/* File: hdl/program_fetch_map.sv */
// program counter, reset vector walk and program store access map
//
// Notes on behaviour
// - store holds 24-bit instructions, upper byte absent
// - lower word even address, upper word odd
// - addresses lower-word aligned, counter steps two
// - vector range below 0x000200 not code space
// - reset starts fetch at the reset vector
`timescale 1ns/1ps
`default_nettype none
module program_fetch_map
  import pmem_pkg::*;
#(
  parameter logic [OP_W-1:0] JUMP_OPCODE = 8'h04
)(
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               reset,
  // core program counter control
  input  wire logic               pc_advance,
  input  wire logic               pc_retreat,
  input  wire logic               pc_load,
  input  wire logic [PC_W-1:0]    pc_load_addr,
  // instruction fetch
  output var  logic [PC_W-1:0]    fetch_pc,
  output var  logic [INSTR_W-1:0] instr,
  output var  logic               instr_valid,
  output var  logic               vector_fault,
  output var  logic               step_refused,
  // data view of program space
  input  wire logic               data_rd,
  input  wire logic [PC_W-1:0]    data_addr,
  output var  logic [WORD_W-1:0]  data_rdata,
  output var  logic               data_rvalid,
  // programming port
  input  wire logic               prog_wr,
  input  wire logic [PC_W-1:0]    prog_addr,
  input  wire logic [WORD_W-1:0]  prog_wdata
);

  pstore_if mem_bus ();

  fetch_state_t    state_r;
  fetch_state_t    state_nxt;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic            op_ok_r;
  logic            op_ok_nxt;
  logic            fault_r;
  logic            fault_nxt;
  logic            refused_r;
  logic            refused_nxt;
  logic            rvalid_r;
  logic            rvalid_nxt;
  logic            rd_hi_r;
  logic            rd_hi_nxt;
  logic [PC_W-1:0] step_pc;
  logic            step_req;
  logic [PC_W-1:0] vec_target;

  // ****************************************************************
  // store
  // ****************************************************************
  program_store u_store (
    .mclk  (mclk),
    .reset (reset),
    .bus   (mem_bus.store)
  );

  // ****************************************************************
  // counter and vector walk
  // ****************************************************************
  assign vec_target = {mem_bus.fa_data[PC_W-1:1], 1'b0};

  always_comb begin
    state_nxt   = state_r;
    pc_nxt      = pc_r;
    op_ok_nxt   = op_ok_r;
    fault_nxt   = fault_r;
    refused_nxt = 1'b0;
    step_pc     = pc_r;
    step_req    = 1'b0;
    case (state_r)
      ST_VEC_OP: begin
        pc_nxt    = VEC_BASE;
        state_nxt = ST_VEC_TGT;
      end
      ST_VEC_TGT: begin
        op_ok_nxt = mem_bus.fa_data[INSTR_W-1:OP_LSB] == JUMP_OPCODE;
        pc_nxt    = TGT_ADDR;
        state_nxt = ST_VEC_JUMP;
      end
      ST_VEC_JUMP: begin
        if (!op_ok_r || vec_target < VEC_TOP) begin
          fault_nxt = 1'b1;
          pc_nxt    = VEC_TOP;
        end else begin
          pc_nxt = vec_target;
        end
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (pc_load) begin
          step_pc  = {pc_load_addr[PC_W-1:1], 1'b0};
          step_req = 1'b1;
        end else if (pc_advance ^ pc_retreat) begin
          step_pc  = pc_advance ? pc_r + PC_STEP : pc_r - PC_STEP;
          step_req = 1'b1;
        end
        if (step_req && step_pc < VEC_TOP) begin
          refused_nxt = 1'b1;
        end else if (step_req) begin
          pc_nxt = step_pc;
        end
      end
      default: begin
        state_nxt = ST_VEC_OP;
        pc_nxt    = PC_RESET;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r   <= ST_VEC_OP;
      pc_r      <= PC_RESET;
      op_ok_r   <= 1'b0;
      fault_r   <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      pc_r      <= pc_nxt;
      op_ok_r   <= op_ok_nxt;
      fault_r   <= fault_nxt;
      refused_r <= refused_nxt;
    end
  end

  // ****************************************************************
  // data view and programming
  // ****************************************************************
  always_comb begin
    rvalid_nxt = data_rd;
    rd_hi_nxt  = data_rd && data_addr[0];
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rvalid_r <= 1'b0;
      rd_hi_r  <= 1'b0;
    end else begin
      rvalid_r <= rvalid_nxt;
      rd_hi_r  <= rd_hi_nxt;
    end
  end

  assign mem_bus.fa_idx  = pc_nxt[IDX_MSB:IDX_LSB];
  assign mem_bus.db_idx  = data_addr[IDX_MSB:IDX_LSB];
  assign mem_bus.db_hi   = data_addr[0];
  assign mem_bus.wr_en   = prog_wr;
  assign mem_bus.wr_hi   = prog_addr[0];
  assign mem_bus.wr_idx  = prog_addr[IDX_MSB:IDX_LSB];
  assign mem_bus.wr_data = prog_wdata;

  assign fetch_pc     = pc_r;
  assign instr        = mem_bus.fa_data;
  assign instr_valid  = state_r == ST_RUN;
  assign vector_fault = fault_r;
  assign step_refused = refused_r;
  assign data_rdata   = mem_bus.db_data;
  assign data_rvalid  = rvalid_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_pc_aligned: assert property (
    @(posedge mclk) disable iff (reset) pc_r[0] == 1'b0)
    else $error("program counter not aligned");

  chk_pc_step: assert property (
    @(posedge mclk) disable iff (reset)
    (state_r == ST_RUN && pc_advance && !pc_retreat && !pc_load
     && pc_r + PC_STEP >= VEC_TOP)
    |=> pc_r == $past(pc_r) + PC_STEP)
    else $error("counter did not advance by two");

  chk_reset_start: assert property (
    @(posedge mclk) disable iff (reset)
    $rose(instr_valid) |-> $past(state_r, 3) == ST_VEC_OP)
    else $error("run entered without vector walk");

  chk_vector_walk: assert property (
    @(posedge mclk) disable iff (reset)
    state_r == ST_VEC_OP |=> state_r == ST_VEC_TGT
    ##1 state_r == ST_VEC_JUMP ##1 (state_r == ST_RUN && pc_r[0] == 1'b0))
    else $error("vector walk out of order");

  chk_run_vec_free: assert property (
    @(posedge mclk) disable iff (reset)
    state_r == ST_RUN |-> pc_r >= VEC_TOP)
    else $error("execution inside vector range");

  chk_load_refused: assert property (
    @(posedge mclk) disable iff (reset)
    (state_r == ST_RUN && pc_load && pc_load_addr < VEC_TOP)
    |=> $stable(pc_r) && step_refused)
    else $error("jump into vector range not refused");

  chk_upper_zero: assert property (
    @(posedge mclk) disable iff (reset)
    rd_hi_r |-> data_rdata[WORD_W-1:UPPER_W] == UPPER_PAD)
    else $error("absent upper byte read nonzero");

  chk_lower_pair: assert property (
    @(posedge mclk) disable iff (reset)
    (prog_wr && !prog_addr[0]) ##1
    (data_rd && data_addr == $past(prog_addr) && !prog_wr)
    |=> data_rdata == $past(prog_wdata, 2))
    else $error("even address lower word mismatch");

  chk_upper_pair: assert property (
    @(posedge mclk) disable iff (reset)
    (prog_wr && prog_addr[0]) ##1
    (data_rd && data_addr == $past(prog_addr) && !prog_wr)
    |=> data_rdata == {UPPER_PAD, $past(prog_wdata[UPPER_W-1:0], 2)})
    else $error("odd address upper word mismatch");

endmodule
`default_nettype wire

/* File: testbench/image_loader.sv */
// stand-in for the programmer that loads an image into the program store
`timescale 1ns/1ps
`default_nettype none
module image_loader
  import pmem_pkg::*;
(
  // clock
  input  wire logic              mclk,
  // control
  input  wire logic              go,
  input  wire logic              bad_vec,
  output var  logic              done,
  // programming port
  output var  logic              prog_wr,
  output var  logic [PC_W-1:0]   prog_addr,
  output var  logic [WORD_W-1:0] prog_wdata
);
  // image: vector at 0 and 2, code at 0x000400 and 0x000402
  // bad vector load also swaps each word pair, ending on a lower word
  int k;
  function automatic logic [WORD_W-1:0] image_word(input int i);
    case (i)
      0: return 16'h0000;
      1: return {8'h00, (bad_vec ? 8'h05 : 8'h04)};
      2: return 16'h0400;
      3: return 16'h0000;
      4: return 16'h1234;
      5: return 16'hff5a;
      6: return 16'habcd;
      default: return 16'h0011;
    endcase
  endfunction

  initial begin
    prog_wr = 1'b0;
    prog_addr = '0;
    prog_wdata = '0;
    done = 1'b0;
    forever begin
      @(posedge go);
      done = 1'b0;
      for (int i = 0; i < 8; i++) begin
        @(negedge mclk);
        k = bad_vec ? (i ^ 1) : i;
        prog_wr = 1'b1;
        prog_addr = (k < 4) ? 24'(k) : 24'(k + 32'h3fc);
        prog_wdata = image_word(k);
      end
      @(negedge mclk);
      prog_wr = 1'b0;
      prog_addr = ~prog_addr;
      prog_wdata = ~prog_wdata;
      done = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/program_fetch_map_bench.sv */
// self-checking bench for the program fetch and store map
`timescale 1ns/1ps
`default_nettype none
module program_fetch_map_bench;
  import pmem_pkg::*;
  logic              mclk;
  logic              reset;
  logic              pc_advance;
  logic              pc_retreat;
  logic              pc_load;
  logic [PC_W-1:0]   pc_load_addr;
  logic [PC_W-1:0]   fetch_pc;
  logic [INSTR_W-1:0] instr;
  logic              instr_valid;
  logic              vector_fault;
  logic              step_refused;
  logic              data_rd;
  logic [PC_W-1:0]   data_addr;
  logic [WORD_W-1:0] data_rdata;
  logic              data_rvalid;
  logic              prog_wr;
  logic [PC_W-1:0]   prog_addr;
  logic [WORD_W-1:0] prog_wdata;
  logic              go;
  logic              bad_vec;
  logic              done;
  int                err_total;
  int                n_compared;
  int                cycles;
  logic [PC_W-1:0]   row_addr [7] = '{24'h0, 24'h1, 24'h2, 24'h3,
                                      24'h400, 24'h402, 24'h403};
  logic [WORD_W-1:0] row_exp [7] = '{16'h0000, 16'h0004, 16'h0400,
                                     16'h0000, 16'h1234, 16'habcd, 16'h0011};

  program_fetch_map u_dut (.mclk(mclk), .reset(reset),
    .pc_advance(pc_advance), .pc_retreat(pc_retreat), .pc_load(pc_load),
    .pc_load_addr(pc_load_addr), .fetch_pc(fetch_pc), .instr(instr),
    .instr_valid(instr_valid), .vector_fault(vector_fault),
    .step_refused(step_refused), .data_rd(data_rd), .data_addr(data_addr),
    .data_rdata(data_rdata), .data_rvalid(data_rvalid), .prog_wr(prog_wr),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata));
  image_loader u_load (.mclk(mclk), .go(go), .bad_vec(bad_vec), .done(done),
    .prog_wr(prog_wr), .prog_addr(prog_addr), .prog_wdata(prog_wdata));

  always #12.5 mclk = ~mclk;

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [PC_W-1:0] seen,
                       input logic [PC_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic step(input logic adv, input logic ret, input logic ld,
                      input logic [PC_W-1:0] la);
    @(negedge mclk);
    pc_advance = adv;
    pc_retreat = ret;
    pc_load = ld;
    pc_load_addr = la;
    @(negedge mclk);
    pc_advance = 1'b0;
    pc_retreat = 1'b0;
    pc_load = 1'b0;
  endtask

  task automatic rd(input logic [PC_W-1:0] a);
    @(negedge mclk);
    data_rd = 1'b1;
    data_addr = a;
    @(negedge mclk);
    data_rd = 1'b0;
  endtask

  task automatic load_and_reset(input logic bad);
    @(negedge mclk);
    bad_vec = bad;
    go = 1'b0;
    @(negedge mclk);
    go = 1'b1;
    @(posedge done);
    data_rd = 1'b1;
    data_addr = bad ? 24'h000402 : 24'h000403;
    @(negedge mclk);
    data_rd = 1'b0;
    check("load done", done, 1'b1);
    check("fresh word", data_rdata, bad ? 16'habcd : 16'h0011);
    reset = 1'b1;
    #1;
    check("pc in reset", fetch_pc, PC_RESET);
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    for (int k = 0; k < 8 && instr_valid !== 1'b1; k++) @(negedge mclk);
    check("instr_valid", instr_valid, 1'b1);
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 1000) begin
      err_total++;
      complete_run();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    {pc_advance, pc_retreat, pc_load, data_rd, go, bad_vec} = '0;
    pc_load_addr = '0;
    data_addr = '0;
    @(negedge mclk);
    go = 1'b1;
    repeat (11) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    load_and_reset(1'b0);
    check("start pc", fetch_pc, 24'h000400);
    check("start instr", instr, 24'h5a1234);
    check("no fault", vector_fault, 1'b0);
    for (int i = 0; i < 7; i++) begin
      rd(row_addr[i]);
      check("data_rvalid", data_rvalid, 1'b1);
      check("data_rdata", data_rdata, row_exp[i]);
    end
    rd(24'h000401);
    check("upper pad", data_rdata, 16'h005a);
    step(1'b1, 1'b0, 1'b0, 24'h0);
    check("advance pc", fetch_pc, 24'h000402);
    check("advance instr", instr, 24'h11abcd);
    step(1'b0, 1'b1, 1'b0, 24'h0);
    check("retreat pc", fetch_pc, 24'h000400);
    step(1'b1, 1'b1, 1'b0, 24'h0);
    check("both held", fetch_pc, 24'h000400);
    step(1'b1, 1'b0, 1'b1, 24'h000404);
    check("load priority", fetch_pc, 24'h000404);
    step(1'b0, 1'b0, 1'b1, 24'h000403);
    check("aligned load", fetch_pc, 24'h000402);
    step(1'b0, 1'b0, 1'b1, 24'h0001fe);
    check("refused flag", step_refused, 1'b1);
    check("refused pc", fetch_pc, 24'h000402);
    step(1'b0, 1'b0, 1'b1, VEC_TOP);
    check("edge load", fetch_pc, VEC_TOP);
    step(1'b0, 1'b1, 1'b0, 24'h0);
    check("retreat refused", step_refused, 1'b1);
    check("retreat held", fetch_pc, VEC_TOP);
    step(1'b0, 1'b0, 1'b0, 24'h0);
    check("refused pulse", step_refused, 1'b0);
    load_and_reset(1'b1);
    check("bad vector", vector_fault, 1'b1);
    check("bad vector pc", fetch_pc, VEC_TOP);
    complete_run();
  end
endmodule
`default_nettype wire
